// ### hw/stda_top.sv
/*
  Four-wire scan test port with its sixteen-state controller, private debug
  chains, breakpoint unit and an APB register window for the CPU side.
  Assumes tck, tms and tdi arrive from pins asynchronous to pclk, with tck
  much slower than pclk; fuses and lock bits are static levels on pclk.
*/
// Added by the designer: register access over APB and the placing of the registers.
//
// Function
// - Only mode select, clock, data in and out exist; no test reset input.
// - Fuse unprogrammed: pins serve as port pins, controller held in reset.
// - Fuse programmed and disable bit clear: port enabled, input pull-ups on.
// - Data out is driven only in shifting states, floating otherwise.
// - Sixteen-state controller steps on mode select at test clock rises.
// - After power-on reset the controller sits in Test-Logic-Reset.
// - All chains move least significant bit first.
// - Four-bit instruction; select low for three bits, high on the last.
// - Instruction shifting sends out the captured value 0x01.
// - Update-IR loads the instruction; 1,1,0 returns to Run-Test/Idle.
// - 1,0,0 reaches Shift-DR; instruction picks the chain shifted there.
// - Data shifting sends out values captured in Capture-DR.
// - Latched chain outputs change only in Update-DR.
// - Five clocks with mode select high reach Test-Logic-Reset.
// - Codes 0x8 to 0xB are private debug instructions.
// - Flow change break, single step, two program and two combined breakpoints.
// - Breakpoints split 4+0, 3+1, 2+2 or 2 plus one masked range.
// - Debug works only with debug fuse programmed and no lock bit set.
// - Debug feeds CPU instructions; CPU answers through a mapped location.
// - Identification code is the default instruction after reset.
`timescale 1ns/1ns
`default_nettype none
`include "stda_params.svh"
module stda_top #(
  parameter int AW = 16,
  parameter logic [31:0] ID_VALUE = 32'h1234_5001 // Arbitrary value, LSB fixed at one.
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic pins_as_port,
  output logic tap_pullup_en,
  input wire logic scan_port_fuse,
  input wire logic debug_enable_fuse,
  input wire logic [1:0] lock_bits,
  input wire logic [AW-1:0] cpu_pc,
  input wire logic cpu_fetch,
  input wire logic cpu_flow_change,
  input wire logic [AW-1:0] cpu_data_addr,
  input wire logic cpu_data_valid,
  output logic [15:0] cpu_insn,
  output logic cpu_insn_stb,
  output logic break_req,
  output logic debug_en
);

  localparam int DRW = `STDA_DR_W;

  // Two-stage synchronisers for the pins, plus one delayed copy of tck.
  logic tck_m_r, tck_s_r, tck_d_r, tms_m_r, tms_s_r, tdi_m_r, tdi_s_r;
  logic tck_rise, tck_fall;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tck_m_r, tck_s_r, tck_d_r} <= 3'h0;
      {tms_m_r, tms_s_r, tdi_m_r, tdi_s_r} <= 4'hf;
    end
    else
    begin
      {tck_m_r, tck_s_r, tck_d_r} <= {tck, tck_m_r, tck_s_r};
      {tms_m_r, tms_s_r, tdi_m_r, tdi_s_r} <= {tms, tms_m_r, tdi, tdi_m_r};
    end
  end
  assign tck_rise = tck_s_r && !tck_d_r;
  assign tck_fall = !tck_s_r && tck_d_r;

  // Port enable and debug gating from fuses, lock bits and the disable bit.
  logic ctrl_dis_r, ctrl_dis_nxt, tap_en, dbg_ok;
  assign tap_en = scan_port_fuse && !ctrl_dis_r;
  assign dbg_ok = debug_enable_fuse && (lock_bits == 2'h0);

  // Controller next-state table, stepping on sampled mode select.
  function automatic stda_pkg::stda_state_t step(input stda_pkg::stda_state_t s,
                                                 input logic m);
    unique case (s)
      stda_pkg::ST_RESET: step = m ? stda_pkg::ST_RESET : stda_pkg::ST_IDLE;
      stda_pkg::ST_IDLE: step = m ? stda_pkg::ST_SEL_DR : stda_pkg::ST_IDLE;
      stda_pkg::ST_SEL_DR: step = m ? stda_pkg::ST_SEL_IR : stda_pkg::ST_CAPTURE_DR;
      stda_pkg::ST_CAPTURE_DR: step = m ? stda_pkg::ST_EXIT1_DR : stda_pkg::ST_SHIFT_DR;
      stda_pkg::ST_SHIFT_DR: step = m ? stda_pkg::ST_EXIT1_DR : stda_pkg::ST_SHIFT_DR;
      stda_pkg::ST_EXIT1_DR: step = m ? stda_pkg::ST_UPDATE_DR : stda_pkg::ST_PAUSE_DR;
      stda_pkg::ST_PAUSE_DR: step = m ? stda_pkg::ST_EXIT2_DR : stda_pkg::ST_PAUSE_DR;
      stda_pkg::ST_EXIT2_DR: step = m ? stda_pkg::ST_UPDATE_DR : stda_pkg::ST_SHIFT_DR;
      stda_pkg::ST_UPDATE_DR: step = m ? stda_pkg::ST_SEL_DR : stda_pkg::ST_IDLE;
      stda_pkg::ST_SEL_IR: step = m ? stda_pkg::ST_RESET : stda_pkg::ST_CAPTURE_IR;
      stda_pkg::ST_CAPTURE_IR: step = m ? stda_pkg::ST_EXIT1_IR : stda_pkg::ST_SHIFT_IR;
      stda_pkg::ST_SHIFT_IR: step = m ? stda_pkg::ST_EXIT1_IR : stda_pkg::ST_SHIFT_IR;
      stda_pkg::ST_EXIT1_IR: step = m ? stda_pkg::ST_UPDATE_IR : stda_pkg::ST_PAUSE_IR;
      stda_pkg::ST_PAUSE_IR: step = m ? stda_pkg::ST_EXIT2_IR : stda_pkg::ST_PAUSE_IR;
      stda_pkg::ST_EXIT2_IR: step = m ? stda_pkg::ST_UPDATE_IR : stda_pkg::ST_SHIFT_IR;
      stda_pkg::ST_UPDATE_IR: step = m ? stda_pkg::ST_SEL_DR : stda_pkg::ST_IDLE;
    endcase
  endfunction : step

  // Controller, instruction and data chains, and the falling-edge output.
  stda_pkg::stda_state_t state_r, state_nxt;
  logic [3:0] ir_r, ir_nxt, ir_sr_r, ir_sr_nxt;
  logic [DRW-1:0] dr_sr_r, dr_sr_nxt, brk_cfg_r, brk_cfg_nxt;
  logic [15:0] insn_r, insn_nxt;
  logic insn_stb_r, insn_stb_nxt, halt_r, halt_nxt, tdo_r, tdo_nxt, oe_r, oe_nxt;
  logic [3:0] sel;
  logic [6:0] dr_len;
  logic comm_clr, dirty_r;
  logic [6:0] comm_r;

  // Private opcodes only open the debug chains while debug is allowed.
  always_comb
  begin
    sel = ir_r;
    if (ir_r[3:2] == 2'h2 && !dbg_ok)
      sel = `STDA_IR_BYPASS;
    unique case (sel)
      `STDA_IR_IDCODE: dr_len = `STDA_LEN_ID;
      `STDA_IR_OP0: dr_len = `STDA_LEN_INSN;
      `STDA_IR_OP1: dr_len = `STDA_LEN_BRK;
      `STDA_IR_OP2: dr_len = `STDA_LEN_COMM;
      default: dr_len = `STDA_LEN_ONE;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    ir_nxt = ir_r;
    ir_sr_nxt = ir_sr_r;
    dr_sr_nxt = dr_sr_r;
    brk_cfg_nxt = brk_cfg_r;
    insn_nxt = insn_r;
    insn_stb_nxt = 1'b0;
    halt_nxt = halt_r;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    comm_clr = 1'b0;
    if (!tap_en)
    begin
      // No test reset pin: only presetn, the fuse or the disable bit force reset.
      state_nxt = stda_pkg::ST_RESET;
      ir_nxt = `STDA_IR_IDCODE;
      oe_nxt = 1'b0;
    end
    else if (tck_rise)
    begin
      state_nxt = step(state_r, tms_s_r);
      unique case (state_r)
        stda_pkg::ST_RESET: ir_nxt = `STDA_IR_IDCODE;
        stda_pkg::ST_CAPTURE_IR: ir_sr_nxt = `STDA_IR_CAPTURE;
        stda_pkg::ST_SHIFT_IR: ir_sr_nxt = {tdi_s_r, ir_sr_r[3:1]};
        stda_pkg::ST_UPDATE_IR: ir_nxt = ir_sr_r;
        stda_pkg::ST_CAPTURE_DR:
        begin
          // Parallel values are loaded here and shifted out next.
          dr_sr_nxt = '0;
          unique case (sel)
            `STDA_IR_IDCODE: dr_sr_nxt[31:0] = ID_VALUE;
            `STDA_IR_OP0: dr_sr_nxt[AW-1:0] = cpu_pc;
            `STDA_IR_OP1: dr_sr_nxt = brk_cfg_r;
            `STDA_IR_OP2:
            begin
              dr_sr_nxt[7:0] = {dirty_r, comm_r};
              comm_clr = 1'b1;
            end
            default: dr_sr_nxt[0] = 1'b0;
          endcase
        end
        stda_pkg::ST_SHIFT_DR:
        begin
          // Data in enters at the chain's top bit; bit zero leaves first.
          dr_sr_nxt = dr_sr_r >> 1;
          dr_sr_nxt[dr_len - 7'h01] = tdi_s_r;
        end
        stda_pkg::ST_UPDATE_DR:
        begin
          unique case (sel)
            `STDA_IR_OP0:
            begin
              insn_nxt = dr_sr_r[15:0];
              insn_stb_nxt = 1'b1;
            end
            `STDA_IR_OP1: brk_cfg_nxt = dr_sr_r;
            `STDA_IR_OP3: halt_nxt = dr_sr_r[0];
            default: halt_nxt = halt_r;
          endcase
        end
        default: state_nxt = step(state_r, tms_s_r);
      endcase
      // Entering Test-Logic-Reset reloads the default instruction at once.
      if (state_nxt == stda_pkg::ST_RESET)
        ir_nxt = `STDA_IR_IDCODE;
    end
    else if (tck_fall)
    begin
      // Output moves half a test clock ahead of the far end's sampling edge.
      tdo_nxt = (state_r == stda_pkg::ST_SHIFT_IR) ? ir_sr_r[0] : dr_sr_r[0];
      oe_nxt = (state_r == stda_pkg::ST_SHIFT_IR) || (state_r == stda_pkg::ST_SHIFT_DR);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= stda_pkg::ST_RESET;
      ir_r <= `STDA_IR_IDCODE;
      ir_sr_r <= 4'h0;
      dr_sr_r <= '0;
      brk_cfg_r <= '0;
      insn_r <= 16'h0000;
      insn_stb_r <= 1'b0;
      halt_r <= 1'b0;
      tdo_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ir_r <= ir_nxt;
      ir_sr_r <= ir_sr_nxt;
      dr_sr_r <= dr_sr_nxt;
      brk_cfg_r <= brk_cfg_nxt;
      insn_r <= insn_nxt;
      insn_stb_r <= insn_stb_nxt;
      halt_r <= halt_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Breakpoint comparator set-up from the mode field of the config chain.
  stda_pkg::stda_bpmode_t bp_mode;
  logic [3:0] bp_en, bp_data, hits;
  logic [AW-1:0] bp_mask [4];
  always_comb
  begin
    bp_mode = stda_pkg::stda_bpmode_t'(brk_cfg_r[`STDA_BC_MODE +: 2]);
    bp_en = brk_cfg_r[`STDA_BC_EN +: 4];
    bp_data = 4'h0;
    for (int i = 0; i < 4; i++)
      bp_mask[i] = '0;
    unique case (bp_mode)
      stda_pkg::BP_ALL_PROG: bp_data = 4'h0;
      stda_pkg::BP_THREE_ONE: bp_data = 4'h8;
      stda_pkg::BP_TWO_TWO: bp_data = 4'hc;
      stda_pkg::BP_RANGE:
      begin
        // Comparator three's address serves as the range mask.
        bp_data = {1'b0, brk_cfg_r[`STDA_BC_SPACE], 2'h0};
        bp_mask[2] = brk_cfg_r[3*AW +: AW];
        bp_en[3] = 1'b0;
      end
    endcase
  end

  // Two program comparators and two combined ones.
  for (genvar g = 0; g < 4; g++)
  begin : g_bp
    stda_bpcmp #(.AW(AW)) u_cmp (
      .en(bp_en[g]),
      .is_data(bp_data[g]),
      .bp_addr(brk_cfg_r[g*AW +: AW]),
      .bp_mask(bp_mask[g]),
      .prog_addr(cpu_pc),
      .prog_valid(cpu_fetch),
      .data_addr(cpu_data_addr),
      .data_valid(cpu_data_valid),
      .hit(hits[g])
    );
  end

  // Break request and pin-mode outputs.
  logic brk_r, brk_nxt, dbg_r, port_r, pull_r;
  always_comb
  begin
    brk_nxt = dbg_ok && ((|hits) || halt_r
      || (brk_cfg_r[`STDA_BC_FLOW] && cpu_flow_change)
      || (brk_cfg_r[`STDA_BC_STEP] && cpu_fetch));
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brk_r <= 1'b0;
      dbg_r <= 1'b0;
      port_r <= 1'b1;
      pull_r <= 1'b0;
    end
    else
    begin
      brk_r <= brk_nxt;
      dbg_r <= dbg_ok;
      port_r <= !scan_port_fuse;
      pull_r <= tap_en;
    end
  end

  // APB slave, zero wait: answer prepared in setup, given in access.
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, dirty_nxt, wr;
  logic [6:0] comm_nxt;
  always_comb
  begin
    wr = psel && penable && pready_r && pwrite;
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    ctrl_dis_nxt = ctrl_dis_r;
    comm_nxt = comm_r;
    dirty_nxt = comm_clr ? 1'b0 : dirty_r;
    unique case (paddr)
      `STDA_OFF_CTRL: prdata_nxt[`STDA_CTRL_DIS_BIT] = ctrl_dis_r;
      `STDA_OFF_STATUS: prdata_nxt[9:0] = {brk_r, dbg_r, ir_r, state_r};
      `STDA_OFF_COMM: prdata_nxt[7:0] = {dirty_r, comm_r};
      default: pslverr_nxt = psel && !penable;
    endcase
    if (!(psel && !penable) || pwrite)
      prdata_nxt = 32'h0000_0000;
    if (wr && paddr == `STDA_OFF_CTRL)
      ctrl_dis_nxt = pwdata[`STDA_CTRL_DIS_BIT];
    if (wr && paddr == `STDA_OFF_COMM)
    begin
      // A CPU write wins over a debugger read clearing the flag.
      comm_nxt = pwdata[6:0];
      dirty_nxt = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_dis_r <= `STDA_CTRL_RST;
      comm_r <= 7'h00;
      dirty_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_dis_r <= ctrl_dis_nxt;
      comm_r <= comm_nxt;
      dirty_r <= dirty_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tdo = tdo_r;
  assign tdo_oe = oe_r;
  assign pins_as_port = port_r;
  assign tap_pullup_en = pull_r;
  assign cpu_insn = insn_r;
  assign cpu_insn_stb = insn_stb_r;
  assign break_req = brk_r;
  assign debug_en = dbg_r;

  // Checks: counts test clock rises with mode select high.
  logic [2:0] tms_hi_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tms_hi_r <= 3'h0;
    else if (!tap_en || (tck_rise && !tms_s_r))
      tms_hi_r <= 3'h0;
    else if (tck_rise && tms_hi_r != 3'h7)
      tms_hi_r <= tms_hi_r + 3'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fuse_off_hold_a: assert property (!scan_port_fuse |=> state_r == stda_pkg::ST_RESET)
    else $error("controller left reset with fuse off");
  pullup_follow_a: assert property (presetn |=> tap_pullup_en == $past(tap_en))
    else $error("pull-up enable does not follow port enable");
  tdo_float_a: assert property (tap_en && tck_fall |=>
    tdo_oe == ($past(state_r) inside {stda_pkg::ST_SHIFT_IR, stda_pkg::ST_SHIFT_DR}))
    else $error("output enable wrong after falling edge");
  idle_step_a: assert property (tap_en && tck_rise && state_r == stda_pkg::ST_IDLE && tms_s_r
    |=> state_r == stda_pkg::ST_SEL_DR)
    else $error("idle did not step to select-DR");
  ir_lsb_a: assert property (tap_en && tck_rise && state_r == stda_pkg::ST_SHIFT_IR
    |=> ir_sr_r[3] == $past(tdi_s_r) && ir_sr_r[2:0] == $past(ir_sr_r[3:1]))
    else $error("instruction shift order wrong");
  ir_capture_a: assert property (tap_en && tck_rise && state_r == stda_pkg::ST_CAPTURE_IR
    |=> ir_sr_r == 4'h1)
    else $error("instruction capture value wrong");
  ir_update_a: assert property ($changed(ir_r) |->
    state_r == stda_pkg::ST_RESET || $past(state_r) == stda_pkg::ST_UPDATE_IR)
    else $error("instruction changed outside update");
  dr_update_a: assert property ($changed(brk_cfg_r) || $rose(cpu_insn_stb)
    |-> $past(state_r, 2) == stda_pkg::ST_UPDATE_DR)
    else $error("chain output changed outside update-DR");
  five_high_a: assert property (tms_hi_r >= 3'h5 |-> state_r == stda_pkg::ST_RESET)
    else $error("five high clocks did not reach reset");
  lock_gate_a: assert property (lock_bits != 2'h0 |=> !break_req && !debug_en)
    else $error("debug active with lock bit set");
  default_id_a: assert property (state_r == stda_pkg::ST_RESET |=> ir_r == 4'h1)
    else $error("identification not default in reset");

  shift_ir_c: cover property (tck_rise && state_r == stda_pkg::ST_SHIFT_IR && tms_s_r);
  shift_dr_c: cover property (tck_rise && state_r == stda_pkg::ST_SHIFT_DR && sel == 4'h9);
  break_c: cover property ($rose(break_req));
  comm_c: cover property (dirty_r && comm_clr);

endmodule : stda_top
`default_nettype wire

// ### common/stda_params.svh
/*
  Constants for the scan tap debug access block: register offsets, field
  positions, reset values, instruction codes and scan chain lengths.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef STDA_PARAMS_SVH
`define STDA_PARAMS_SVH

// Register offsets on the APB side, byte addresses of aligned words.
`define STDA_OFF_CTRL 8'h00
`define STDA_OFF_STATUS 8'h04
`define STDA_OFF_COMM 8'h08

// Control register fields and reset values.
`define STDA_CTRL_DIS_BIT 0
`define STDA_CTRL_RST 1'b0

// Instruction register width, capture pattern and opcodes.
`define STDA_IR_W 4
`define STDA_IR_CAPTURE 4'h1
`define STDA_IR_IDCODE 4'h1
`define STDA_IR_BYPASS 4'hf
`define STDA_IR_OP0 4'h8
`define STDA_IR_OP1 4'h9
`define STDA_IR_OP2 4'ha
`define STDA_IR_OP3 4'hb

// Data register shifter width and the length of each chain.
`define STDA_DR_W 73
`define STDA_LEN_ID 7'h20
`define STDA_LEN_INSN 7'h10
`define STDA_LEN_BRK 7'h49
`define STDA_LEN_COMM 7'h08
`define STDA_LEN_ONE 7'h01

// Breakpoint configuration chain field positions.
`define STDA_BC_MODE 64
`define STDA_BC_SPACE 66
`define STDA_BC_STEP 67
`define STDA_BC_FLOW 68
`define STDA_BC_EN 69

`endif

// ### common/stda_pkg.sv
/*
  Types shared by the scan tap debug access block: controller states and
  breakpoint resource modes.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package stda_pkg;

  // Sixteen controller states in the usual binary order.
  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0,
    ST_EXIT1_DR = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR = 4'h4,
    ST_UPDATE_DR = 4'h5,
    ST_CAPTURE_DR = 4'h6,
    ST_SEL_DR = 4'h7,
    ST_EXIT2_IR = 4'h8,
    ST_EXIT1_IR = 4'h9,
    ST_SHIFT_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_IDLE = 4'hc,
    ST_UPDATE_IR = 4'hd,
    ST_CAPTURE_IR = 4'he,
    ST_RESET = 4'hf
  } stda_state_t;

  // How the four breakpoint comparators are shared out.
  typedef enum logic [1:0] {
    BP_ALL_PROG = 2'h0,
    BP_THREE_ONE = 2'h1,
    BP_TWO_TWO = 2'h2,
    BP_RANGE = 2'h3
  } stda_bpmode_t;

endpackage : stda_pkg
`default_nettype wire

// ### hw/stda_bpcmp.sv
/*
  One breakpoint comparator: matches a program or data address against a
  stored address, ignoring the bits set in a mask.
  Assumes address and valid inputs are on the same clock as the caller.
*/
`timescale 1ns/1ns
`default_nettype none
module stda_bpcmp #(
  parameter int AW = 16
) (
  input wire logic en,
  input wire logic is_data,
  input wire logic [AW-1:0] bp_addr,
  input wire logic [AW-1:0] bp_mask,
  input wire logic [AW-1:0] prog_addr,
  input wire logic prog_valid,
  input wire logic [AW-1:0] data_addr,
  input wire logic data_valid,
  output logic hit
);

  logic [AW-1:0] cmp_addr;
  logic cmp_valid;

  // Picks the address space, then compares the unmasked bits.
  always_comb
  begin
    cmp_addr = is_data ? data_addr : prog_addr;
    cmp_valid = is_data ? data_valid : prog_valid;
    hit = en && cmp_valid && (((cmp_addr ^ bp_addr) & ~bp_mask) == '0);
  end

endmodule : stda_bpcmp
`default_nettype wire

// ### sim/stda_scan_master.sv
/*
  Model of the external scan controller: drives tck, tms and tdi and samples
  the data out pin. Assumes pclk at 100 ns, so one tck period is 8 pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module stda_scan_master (
  input wire logic pclk,
  input wire logic tdo_pin,
  input wire logic rst_n,
  output var logic rst_pull_n,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  // The link clock rests low and data in idles high between frames.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    rst_pull_n = 1'b1;
  end

  // One frame of n test clocks, bits taken and returned least significant first.
  task automatic shift(input logic [79:0] tv, input logic [79:0] dv, input int n,
    output logic [79:0] qv);
    qv = '0;
    for (int i = 0; i < n; i++)
    begin
      tms <= tv[i];
      tdi <= dv[i];
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      qv[i] = tdo_pin;
      @(posedge pclk);
      tck <= 1'b1;
      repeat (3) @(posedge pclk);
      tck <= 1'b0;
    end
    @(posedge pclk);
    tdi <= 1'b1;
  endtask : shift

  // Pulls the open-collector reset line low and reports whether it went low.
  task automatic pull_reset(output logic seen);
    rst_pull_n <= 1'b0;
    repeat (3) @(posedge pclk);
    seen = !rst_n;
    rst_pull_n <= 1'b1;
  endtask : pull_reset
endmodule : stda_scan_master
`default_nettype wire

// ### sim/test_stda_top.sv
/*
  Self-checking bench for the scan test port block.
  Assumes the package, the design files and the scan master are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "stda_params.svh"
module test_stda_top;
  localparam logic [31:0] TB_ID = 32'h0bad_f00d; // Arbitrary value, LSB one.
  logic pclk, rst_src_n, rst_pull_n, psel, penable, pwrite, pready, pslverr, e;
  logic tck, tms, tdi, tdo, tdo_oe, pins_as_port, tap_pullup_en, debug_en;
  logic scan_port_fuse, debug_enable_fuse, cpu_fetch, cpu_flow_change;
  logic cpu_data_valid, cpu_insn_stb, break_req;
  logic [1:0] lock_bits;
  logic [7:0] paddr;
  logic [15:0] cpu_pc, cpu_data_addr, cpu_insn;
  logic [31:0] pwdata, prdata, q;
  logic [79:0] so;
  int mismatches, tests_run, stbs;
  wire logic tdo_pin;
  wire logic presetn;

  // The reset line is wired-AND of the bench's source and the debugger's pull.
  assign presetn = rst_src_n && rst_pull_n;

  // The data out line has a pull-up where the port leaves it floating.
  assign tdo_pin = tdo_oe ? tdo : 1'b1;

  stda_top #(.ID_VALUE(TB_ID)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .pins_as_port, .tap_pullup_en, .scan_port_fuse, .debug_enable_fuse, .lock_bits,
    .cpu_pc, .cpu_fetch, .cpu_flow_change, .cpu_data_addr, .cpu_data_valid,
    .cpu_insn, .cpu_insn_stb, .break_req, .debug_en);
  stda_scan_master m (.pclk, .tdo_pin, .rst_n(presetn), .rst_pull_n, .tck, .tms, .tdi);

  // System clock at 10 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Counts the strobes that announce a fed-in instruction.
  always @(posedge pclk)
    if (cpu_insn_stb === 1'b1)
      stbs <= stbs + 1;

  task chk(input logic [79:0] got, input logic [79:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      mismatches++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task sh(input logic [79:0] t, input logic [79:0] d, input int n);
    @(posedge pclk);
    m.shift(t, d, n, so);
  endtask : sh

  // Idle to Shift-IR, four bits, back to idle.
  task ir(input logic [3:0] op);
    sh(80'h183, {72'h0, op, 4'h0}, 10);
  endtask : ir

  // Idle to Shift-DR, n bits, back to idle; the shifted out bits land in so.
  task dr(input int n, input logic [79:0] din);
    sh(80'h1 | (80'h3 << (n + 2)), din << 3, n + 5);
    so = (so >> 3) & ((80'h1 << n) - 80'h1);
  endtask : dr

  task t_fuse_off;
    sh(80'h0, 80'h0, 4);
    chk(pins_as_port, 1'b1);
    chk(tap_pullup_en, 1'b0);
    apb(1'b0, `STDA_OFF_STATUS, 32'h0);
    chk(q[3:0], stda_pkg::ST_RESET);
    chk(tdo_oe, 1'b0);
  endtask : t_fuse_off

  task t_enable;
    scan_port_fuse <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({pins_as_port, tap_pullup_en}, 2'h1);
    apb(1'b1, `STDA_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(tap_pullup_en, 1'b0);
    apb(1'b1, `STDA_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h0c, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    chk(tap_pullup_en, 1'b1);
  endtask : t_enable

  task t_idcode;
    sh(80'h0, 80'h0, 1);
    apb(1'b0, `STDA_OFF_STATUS, 32'h0);
    chk(q[3:0], stda_pkg::ST_IDLE);
    dr(32, 80'h0);
    chk(so, TB_ID);
  endtask : t_idcode

  task t_bypass;
    ir(4'hf);
    chk(so[7:4], 4'h1);
    apb(1'b0, `STDA_OFF_STATUS, 32'h0);
    chk(q[7:0], {4'hf, stda_pkg::ST_IDLE});
    dr(4, 80'hb);
    chk(so, 80'h6);
    chk(tdo_oe, 1'b0);
  endtask : t_bypass

  task t_insn;
    cpu_pc <= 16'h3c5a;
    chk(debug_en, 1'b1);
    ir(4'h8);
    dr(16, 80'ha5c3);
    chk(so, 80'h3c5a);
    @(posedge pclk);
    chk({stbs[3:0], cpu_insn}, 20'h1_a5c3);
    lock_bits <= 2'h2;
    repeat (3) @(posedge pclk);
    chk(debug_en, 1'b0);
    dr(16, 80'h1);
    chk(so, 80'h2);
    chk(cpu_insn, 16'ha5c3);
    lock_bits <= 2'h0;
  endtask : t_insn

  task t_comm;
    apb(1'b1, `STDA_OFF_COMM, 32'h0000_0055);
    apb(1'b0, `STDA_OFF_COMM, 32'h0);
    chk(q[7:0], 8'hd5);
    ir(4'ha);
    dr(8, 80'h0);
    chk(so, 80'hd5);
    apb(1'b0, `STDA_OFF_COMM, 32'h0);
    chk(q[7:0], 8'h55);
  endtask : t_comm

  task t_break;
    ir(4'h9);
    dr(73, (80'h1 << 72) | (80'h1 << 64) | (80'h0456 << 48));
    cpu_pc <= 16'h0456;
    cpu_fetch <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(break_req, 1'b0);
    cpu_fetch <= 1'b0;
    cpu_data_addr <= 16'h0456;
    cpu_data_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(break_req, 1'b1);
    cpu_data_valid <= 1'b0;
    dr(73, (80'h4 << 69) | (80'h1 << 68) | (80'h3 << 64) | (80'h000f << 48) | (80'h0450 << 32));
    cpu_pc <= 16'h045a;
    cpu_fetch <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(break_req, 1'b1);
    cpu_pc <= 16'h0460;
    repeat (3) @(posedge pclk);
    chk(break_req, 1'b0);
    cpu_fetch <= 1'b0;
    cpu_flow_change <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(break_req, 1'b1);
    cpu_flow_change <= 1'b0;
    ir(4'hb);
    dr(1, 80'h1);
    @(posedge pclk);
    chk({so[0], break_req}, 2'h1);
    dr(1, 80'h0);
    @(posedge pclk);
    chk(break_req, 1'b0);
  endtask : t_break

  task t_tlr;
    sh(80'h1, 80'h0, 3);
    repeat (5) @(posedge pclk);
    chk(tdo_oe, 1'b1);
    sh(80'h1f, 80'h0, 5);
    apb(1'b0, `STDA_OFF_STATUS, 32'h0);
    chk(q[7:0], {4'h1, stda_pkg::ST_RESET});
    chk(tdo_oe, 1'b0);
  endtask : t_tlr

  // Debugger pulls the reset line in mid-run; the port must restart cleanly.
  task t_reset;
    m.pull_reset(e);
    chk(e, 1'b1);
    chk({pins_as_port, tap_pullup_en, break_req, debug_en, tdo_oe}, 5'h10);
    apb(1'b0, `STDA_OFF_STATUS, 32'h0);
    chk({cpu_insn, q[9:0]}, {16'h0000, 2'h1, 4'h1, stda_pkg::ST_RESET});
    sh(80'h0, 80'h0, 1);
    dr(32, 80'h0);
    chk(so, TB_ID);
  endtask : t_reset

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial
  begin
    rst_src_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    scan_port_fuse = 1'b0;
    debug_enable_fuse = 1'b1;
    lock_bits = 2'h0;
    cpu_pc = 16'h0;
    cpu_fetch = 1'b0;
    cpu_flow_change = 1'b0;
    cpu_data_addr = 16'h0;
    cpu_data_valid = 1'b0;
    repeat (10) @(posedge pclk);
    rst_src_n <= 1'b1;
    t_fuse_off();
    t_enable();
    t_idcode();
    t_bypass();
    t_insn();
    t_comm();
    t_break();
    t_tlr();
    t_reset();
    end_sim();
  end
endmodule : test_stda_top
`default_nettype wire
